// ==== boot_config_pkg.sv ====
// Purpose: shared constants and types for the boot configuration latch block
// Assumes: 32-bit AHB-Lite register access, one word per latch byte
// Notes: byte index times four gives the byte address
`default_nettype none
package boot_config_pkg;
    // ------------------------------------------------------------
    // latch indices and byte addresses
    // ------------------------------------------------------------
    localparam int LATCH_COUNT = 4;                          // four latch bytes
    localparam logic [1:0] IDX_PORT_LOW = 2'h0;              // port_drive_modes_low
    localparam logic [1:0] IDX_PORT_HIGH = 2'h1;             // port_drive_modes_high
    localparam logic [1:0] IDX_RST_DBG = 2'h2;               // reset_debug_enables
    localparam logic [1:0] IDX_CLK_ECC = 2'h3;               // boot_clock_ecc_debugport
    localparam logic [7:0] ADDR_STATUS = 8'h10;              // applied configuration readback
    localparam logic [7:0] ADDR_CTRL = 8'h14;                // write lock control
    localparam logic [7:0] ADDR_WRCOUNT = 8'h18;             // latch rewrite counter
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_EXT_RESET = 7;                        // ext_reset_pin_select
    localparam int POS_DEBUG_EN = 6;                         // debug_access_enable
    localparam int POS_PORT15 = 4;                           // port 15 drive mode low bit
    localparam int POS_PHASE = 4;                            // digital_clock_phase_delay low bit
    localparam int POS_ECC = 3;                              // ecc_area_enable
    localparam int POS_DPS = 1;                              // debug_port_select low bit
    localparam int POS_SPEED = 0;                            // boot_clock_speed
    // ------------------------------------------------------------
    // factory defaults
    // ------------------------------------------------------------
    localparam logic [7:0] DEF_PORT_LOW = 8'h00;             // all ports analog hi-z
    localparam logic [7:0] DEF_PORT_HIGH = 8'h00;
    localparam logic [7:0] DEF_RST_DBG = 8'h40;              // debug enabled, gpio pin
    localparam logic [7:0] DEF_CLK_ECC = 8'h0A;              // ecc on, 4-wire jtag, 12 MHz
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_HIZ_ANALOG = 2'h0,
        DRV_HIZ_DIGITAL = 2'h1,
        DRV_PULL_UP = 2'h2,
        DRV_PULL_DOWN = 2'h3
    } drive_mode_e;
    typedef enum logic [1:0] {
        DBG_JTAG5 = 2'h0,
        DBG_JTAG4 = 2'h1,
        DBG_SWD = 2'h2,
        DBG_OFF = 2'h3
    } debug_port_e;
    // applied configuration seen by the rest of the chip
    typedef struct packed {
        logic [1:0] port15Mode;
        logic [1:0] port12Mode;
        logic [1:0] port6Mode;
        logic [1:0] port5Mode;
        logic [1:0] port4Mode;
        logic [1:0] port3Mode;
        logic [1:0] port2Mode;
        logic [1:0] port1Mode;
        logic [1:0] port0Mode;
        logic extResetSelect;
        logic debugAccessEnable;
        logic bootClock48;
        logic eccAreaEnable;
        logic [1:0] debugPortSelect;
        logic [3:0] phaseDelay;
    } boot_cfg_s;
    // ------------------------------------------------------------
    // apply sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_APPLY = 3'h2,
        ST_RUN = 3'h4
    } apply_state_e;
    localparam int PORT_PINS = 8;                            // pins per port
    localparam logic [7:0] PINS_ALL = 8'hFF;
endpackage : boot_config_pkg
`default_nettype wire

// ==== port_drive_fanout.sv ====
// Purpose: spread one port's reset drive mode over all its pins
// Assumes: mode applied uniformly, no per-pin override
// Notes: one instance per configurable port
`default_nettype none
module port_drive_fanout
    import boot_config_pkg::*;
(
    // mode in
    input wire logic [1:0] mode,
    // per-pin controls out
    output logic [PORT_PINS-1:0] pinAnalog,
    output logic [PORT_PINS-1:0] pinDigitalIn,
    output logic [PORT_PINS-1:0] pinPullUp,
    output logic [PORT_PINS-1:0] pinPullDown
);
    // ------------------------------------------------------------
    // decode once, replicate to every pin
    // ------------------------------------------------------------
    wire isAnalog = (mode == DRV_HIZ_ANALOG);
    wire isDigital = (mode == DRV_HIZ_DIGITAL);
    wire isUp = (mode == DRV_PULL_UP);
    wire isDown = (mode == DRV_PULL_DOWN);
    assign pinAnalog = isAnalog ? PINS_ALL : 8'h00;
    assign pinDigitalIn = isDigital ? PINS_ALL : 8'h00;
    assign pinPullUp = isUp ? PINS_ALL : 8'h00;
    assign pinPullDown = isDown ? PINS_ALL : 8'h00;
endmodule : port_drive_fanout
`default_nettype wire

// ==== boot_config_latches.sv ====
// Purpose: four configuration latch bytes applied at every reset
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: latch storage keeps value across sys_rst; only power-up defaults
// Overview of operation
// - four latch bytes, applied each reset
// - byte layout: ports, port15/enables, clock fields
// - drive mode codes: analog, digital, up, down
// - same mode to every pin of port
// - bit7 byte2 selects external reset pin
// - bit6 byte2 enables debug, default one
// - bit0 byte3 boot clock 12/48 MHz
// - debug port select jtag5/jtag4/swd/off
// - bit3 byte3 dedicates ecc flash area
// - four-bit phase delay field in byte3
`default_nettype none
module boot_config_latches
    import boot_config_pkg::*;
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // applied configuration
    output boot_cfg_s bootCfg,
    output logic cfgValid,
    // per-pin reset drive controls, ports 0-6, 12, 15
    output logic [9*PORT_PINS-1:0] pinAnalog,
    output logic [9*PORT_PINS-1:0] pinDigitalIn,
    output logic [9*PORT_PINS-1:0] pinPullUp,
    output logic [9*PORT_PINS-1:0] pinPullDown,
    // decoded debug and clock controls
    output logic jtagEnable,
    output logic jtagTrstUsed,
    output logic swdEnable,
    output logic bootClockSel48
);
    // ------------------------------------------------------------
    // latch storage
    // ------------------------------------------------------------
    // nonvolatile model: no reset term, so sys_rst does not wipe it
    logic [7:0] latch_q [LATCH_COUNT];
    logic latchInit_q = 1'b0;                   // power-up default load done
    logic [15:0] writeCount_q = 16'h0000;       // rewrite wear counter
    logic writeLock_q;                          // software write lock
    // ------------------------------------------------------------
    // applied configuration and state
    // ------------------------------------------------------------
    boot_cfg_s cfg_q;                           // applied copy
    apply_state_e state_q;                      // apply sequencer
    apply_state_e state_d;
    // ------------------------------------------------------------
    // ahb address phase capture
    // ------------------------------------------------------------
    logic dpValid_q;                            // data phase pending
    logic dpWrite_q;                            // pending is write
    logic [7:0] dpAddr_q;                       // pending byte address
    wire addrPhase = hsel && hready && htrans[1];
    wire wordSize = (hsize == 3'h2);
    // ------------------------------------------------------------
    // decode of the pending data phase
    // ------------------------------------------------------------
    wire isLatch = (dpAddr_q[7:4] == 4'h0);
    wire [1:0] latchIdx = dpAddr_q[3:2];
    wire isStatus = (dpAddr_q == ADDR_STATUS);
    wire isCtrl = (dpAddr_q == ADDR_CTRL);
    wire isCount = (dpAddr_q == ADDR_WRCOUNT);
    wire doWrite = clkEn && dpValid_q && dpWrite_q;
    wire latchWrite = doWrite && isLatch && !writeLock_q;
    wire ctrlWrite = doWrite && isCtrl;
    // status word packs the applied fields as reset/debug, port high, clock/ecc, port low bytes
    wire [31:0] statusWord = {cfg_q.extResetSelect, cfg_q.debugAccessEnable, 1'b0,
        cfg_q.port15Mode, 3'h0,
        cfg_q.port12Mode, cfg_q.port6Mode, cfg_q.port5Mode, cfg_q.port4Mode,
        cfg_q.phaseDelay, cfg_q.eccAreaEnable, cfg_q.debugPortSelect, cfg_q.bootClock48,
        cfg_q.port3Mode, cfg_q.port2Mode, cfg_q.port1Mode, cfg_q.port0Mode};
    wire [31:0] readMux = isLatch ? {24'h000000, latch_q[latchIdx]} :
                          isStatus ? statusWord :
                          isCtrl ? {31'h00000000, writeLock_q} :
                          isCount ? {16'h0000, writeCount_q} :
                          32'h00000000;
    // ------------------------------------------------------------
    // bus response: zero wait, always okay
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // data phase tracking
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            dpValid_q <= 1'b0;
            dpWrite_q <= 1'b0;
            dpAddr_q <= 8'h00;
        end
        else if (clkEn && hready)
        begin
            // non-word writes are ignored rather than merged
            dpValid_q <= addrPhase && wordSize;
            dpWrite_q <= hwrite;
            dpAddr_q <= haddr[7:0];
        end
    end
    // forwarded values so a read right after a write sees the new byte
    logic [7:0] latchNext [LATCH_COUNT];
    wire lockNext = ctrlWrite ? hwdata[0] : writeLock_q;
    wire [15:0] countNext = (latchWrite && writeCount_q != 16'hFFFF) ?
        writeCount_q + 16'h0001 : writeCount_q;
    genvar gi;
    generate
        for (gi = 0; gi < LATCH_COUNT; gi++)
        begin : g_fwd
            assign latchNext[gi] = (latchWrite && latchIdx == 2'(gi)) ? hwdata[7:0] : latch_q[gi];
        end
    endgenerate
    // decode for the address phase read
    wire [7:0] apAddr = haddr[7:0];
    wire [31:0] readMuxAt = (apAddr[7:4] == 4'h0) ? {24'h000000, latchNext[apAddr[3:2]]} :
                            (apAddr == ADDR_STATUS) ? statusWord :
                            (apAddr == ADDR_CTRL) ? {31'h00000000, lockNext} :
                            (apAddr == ADDR_WRCOUNT) ? {16'h0000, countNext} :
                            32'h00000000;
    // read data registered at the address phase so it stands in the data phase
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h00000000;
        end
        else if (clkEn && addrPhase && !hwrite)
        begin
            hrdata <= readMuxAt;
        end
    end
    // ------------------------------------------------------------
    // latch programming path
    // ------------------------------------------------------------
    // first edge loads factory defaults; later writes persist through sys_rst
    always_ff @(posedge clock)
    begin
        if (!latchInit_q)
        begin
            latch_q[IDX_PORT_LOW] <= DEF_PORT_LOW;
            latch_q[IDX_PORT_HIGH] <= DEF_PORT_HIGH;
            latch_q[IDX_RST_DBG] <= DEF_RST_DBG;
            latch_q[IDX_CLK_ECC] <= DEF_CLK_ECC;
            latchInit_q <= 1'b1;
        end
        else if (latchWrite)
        begin
            latch_q[latchIdx] <= hwdata[7:0];
        end
    end
    // wear counter lets software see how often latches were rewritten
    always_ff @(posedge clock)
    begin
        if (latchInit_q)
        begin
            writeCount_q <= countNext;
        end
    end
    // lock guards against stray rewrites; cleared by reset
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            writeLock_q <= 1'b0;
        end
        else if (ctrlWrite)
        begin
            writeLock_q <= hwdata[0];
        end
    end
    // ------------------------------------------------------------
    // apply sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        case (state_q)
            ST_RESET: state_d = ST_APPLY;
            ST_APPLY: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_RESET;
        endcase
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q <= ST_RESET;
        end
        else if (clkEn && latchInit_q)
        begin
            state_q <= state_d;
        end
    end
    // ------------------------------------------------------------
    // sample the latches once per reset
    // ------------------------------------------------------------
    // only the apply state copies; rewrites later wait for next reset
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cfg_q <= '0;
        end
        else if (clkEn && state_q == ST_APPLY)
        begin
            cfg_q.port0Mode <= latch_q[IDX_PORT_LOW][1:0];
            cfg_q.port1Mode <= latch_q[IDX_PORT_LOW][3:2];
            cfg_q.port2Mode <= latch_q[IDX_PORT_LOW][5:4];
            cfg_q.port3Mode <= latch_q[IDX_PORT_LOW][7:6];
            cfg_q.port4Mode <= latch_q[IDX_PORT_HIGH][1:0];
            cfg_q.port5Mode <= latch_q[IDX_PORT_HIGH][3:2];
            cfg_q.port6Mode <= latch_q[IDX_PORT_HIGH][5:4];
            cfg_q.port12Mode <= latch_q[IDX_PORT_HIGH][7:6];
            cfg_q.port15Mode <= latch_q[IDX_RST_DBG][POS_PORT15+:2];
            cfg_q.extResetSelect <= latch_q[IDX_RST_DBG][POS_EXT_RESET];
            cfg_q.debugAccessEnable <= latch_q[IDX_RST_DBG][POS_DEBUG_EN];
            cfg_q.bootClock48 <= latch_q[IDX_CLK_ECC][POS_SPEED];
            cfg_q.debugPortSelect <= latch_q[IDX_CLK_ECC][POS_DPS+:2];
            cfg_q.eccAreaEnable <= latch_q[IDX_CLK_ECC][POS_ECC];
            cfg_q.phaseDelay <= latch_q[IDX_CLK_ECC][POS_PHASE+:4];
        end
    end
    assign bootCfg = cfg_q;
    assign cfgValid = (state_q == ST_RUN);
    // ------------------------------------------------------------
    // decoded outputs
    // ------------------------------------------------------------
    // debug access gate overrides any port selection
    wire dbgOn = cfg_q.debugAccessEnable && cfgValid;
    assign jtagEnable = dbgOn && (cfg_q.debugPortSelect == DBG_JTAG5
        || cfg_q.debugPortSelect == DBG_JTAG4);
    assign jtagTrstUsed = dbgOn && (cfg_q.debugPortSelect == DBG_JTAG5);
    assign swdEnable = dbgOn && (cfg_q.debugPortSelect == DBG_SWD);
    assign bootClockSel48 = cfg_q.bootClock48;
    // ------------------------------------------------------------
    // per-port drive mode fan-out
    // ------------------------------------------------------------
    wire [17:0] portModes = {cfg_q.port15Mode, cfg_q.port12Mode, cfg_q.port6Mode,
        cfg_q.port5Mode, cfg_q.port4Mode, cfg_q.port3Mode, cfg_q.port2Mode,
        cfg_q.port1Mode, cfg_q.port0Mode};
    generate
        for (gi = 0; gi < 9; gi++)
        begin : g_port
            port_drive_fanout u_fanout (
                .mode(portModes[2*gi+:2]),
                .pinAnalog(pinAnalog[PORT_PINS*gi+:PORT_PINS]),
                .pinDigitalIn(pinDigitalIn[PORT_PINS*gi+:PORT_PINS]),
                .pinPullUp(pinPullUp[PORT_PINS*gi+:PORT_PINS]),
                .pinPullDown(pinPullDown[PORT_PINS*gi+:PORT_PINS])
            );
        end
    endgenerate
endmodule : boot_config_latches
`default_nettype wire

// ==== boot_config_latches_assertions.sv ====
// Purpose: port-level checks of bus answers and applied configuration
// Assumes: ports of boot_config_latches only, one clock domain
// Notes: bound at the foot of this file
`default_nettype none
module boot_cfg_checker
    import boot_config_pkg::*;
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    // bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // applied configuration
    input wire boot_cfg_s bootCfg,
    input wire logic cfgValid,
    input wire logic [9*PORT_PINS-1:0] pinPullUp,
    input wire logic [9*PORT_PINS-1:0] pinPullDown,
    input wire logic jtagEnable,
    input wire logic jtagTrstUsed,
    input wire logic swdEnable,
    input wire logic bootClockSel48
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // word read of a latch byte taken; status is wider, so left out
    wire logic rdTaken = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2 && clkEn && haddr[7:4] == 4'h0;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_latch_upper: assert property (rdTaken |=> hrdata[31:8] == 24'h0)
        else $error("latch read has upper bits set");
    a_apply_delay: assert property ($fell(sys_rst) && clkEn ##1 clkEn |=> cfgValid)
        else $error("config not applied two edges after reset");
    a_apply_wait: assert property ($fell(sys_rst) |-> !cfgValid)
        else $error("config valid straight out of reset");
    a_cfg_hold: assert property (cfgValid && $past(cfgValid) |-> $stable(bootCfg))
        else $error("applied config changed outside reset");
    a_cfg_frozen: assert property (!clkEn && cfgValid |=> $stable(bootCfg) && cfgValid)
        else $error("config moved while clock disabled");
    a_port_uniform: assert property (cfgValid |-> pinPullUp[7:0] == {8{bootCfg.port0Mode == DRV_PULL_UP}})
        else $error("port 0 pull-up pins disagree");
    a_port15_down: assert property (cfgValid |-> pinPullDown[71:64] == {8{bootCfg.port15Mode == DRV_PULL_DOWN}})
        else $error("port 15 pull-down pins disagree");
    a_swd_decode: assert property (cfgValid |-> swdEnable == (bootCfg.debugAccessEnable && bootCfg.debugPortSelect == DBG_SWD))
        else $error("swd enable wrong");
    a_jtag_decode: assert property (cfgValid |-> jtagEnable == (bootCfg.debugAccessEnable && !bootCfg.debugPortSelect[1])
        && jtagTrstUsed == (bootCfg.debugAccessEnable && bootCfg.debugPortSelect == DBG_JTAG5))
        else $error("jtag enables wrong");
    a_boot_speed: assert property (cfgValid |-> bootClockSel48 == bootCfg.bootClock48)
        else $error("boot clock select wrong");
endmodule : boot_cfg_checker
bind boot_config_latches boot_cfg_checker u_boot_cfg_checker (.clock, .sys_rst, .clkEn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .bootCfg, .cfgValid, .pinPullUp, .pinPullDown,
    .jtagEnable, .jtagTrstUsed, .swdEnable, .bootClockSel48);
`default_nettype wire

// ==== boot_config_latches_test.sv ====
// Purpose: directed bus tests of the boot configuration latches
// Assumes: zero-wait slave, latches at word index times four
// Notes: expected values built from the latch byte layout
`default_nettype none
module boot_config_latches_test
    import boot_config_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, cfgValid, jtagEnable, jtagTrstUsed, swdEnable, bootClockSel48;
    logic [71:0] pinAnalog, pinDigitalIn, pinPullUp, pinPullDown;
    boot_cfg_s bootCfg;
    logic [31:0] cur = {DEF_CLK_ECC, DEF_RST_DBG, DEF_PORT_HIGH, DEF_PORT_LOW}; // applied bytes
    int fail_count = 0, tests_run = 0, k;
    always #20 clock = ~clock; // 25 MHz
    boot_config_latches u_boot_config_latches (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bootCfg(bootCfg), .cfgValid(cfgValid),
        .pinAnalog(pinAnalog), .pinDigitalIn(pinDigitalIn), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown),
        .jtagEnable(jtagEnable), .jtagTrstUsed(jtagTrstUsed), .swdEnable(swdEnable),
        .bootClockSel48(bootClockSel48));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one single transfer; waits on hready, bounded
    task xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1; haddr <= addr; htrans <= 2'h2; hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
        rd = hrdata;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask : xfer
    // reset held four cycles, then three edges to apply
    task do_reset;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : do_reset
    // applied config, pins and decodes against bytes w
    task chk_applied(input logic [31:0] w);
        logic [1:0] m;
        logic [7:0] b2, b3;
        b2 = w[23:16];
        b3 = w[31:24];
        chk(32'(cfgValid), 32'h1);
        chk(32'(bootCfg), {4'h0, b2[5:4], w[15:0], b2[7:6], b3[0], b3[3], b3[2:1], b3[7:4]});
        for (int i = 0; i < 9; i++)
        begin
            m = (i == 8) ? b2[5:4] : w[i*2+:2];
            chk({pinAnalog[i*8+:8], pinDigitalIn[i*8+:8], pinPullUp[i*8+:8], pinPullDown[i*8+:8]},
                {{8{m == 2'h0}}, {8{m == 2'h1}}, {8{m == 2'h2}}, {8{m == 2'h3}}});
        end
        chk({jtagEnable, jtagTrstUsed, swdEnable, bootClockSel48}, {b2[6] && !b3[2], b2[6] && b3[2:1] == 2'h0,
            b2[6] && b3[2:1] == 2'h2, b3[0]});
    endtask : chk_applied
    // program, read back, prove hold, reset, prove applied
    task apply(input logic [31:0] w);
        for (int i = 0; i < 4; i++) xfer(1'b1, 32'(i * 4), 32'hFFFFFF00 | w[i*8+:8]);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b0, 32'(i * 4), 32'h0);
            chk(rd, {24'h0, w[i*8+:8]});
        end
        chk_applied(cur);
        cur = w;
        do_reset;
        chk_applied(cur);
    endtask : apply
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        do_reset;
        chk_applied(cur);
        $display("test defaults done");
        apply(32'h5DF01BE4);
        $display("test layout done");
        for (k = 0; k < 5; k++) apply({4'h9, 1'b0, 2'(k), 1'b0, (k < 4) ? 8'h40 : 8'h80, 8'h27, 8'h1B});
        $display("test debug port codes done");
        xfer(1'b0, 32'h40, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, 32'(ADDR_CTRL), 32'h1);
        xfer(1'b1, 32'h0, 32'hAA);
        xfer(1'b0, 32'h0, 32'h0);
        chk(rd, {24'h0, cur[7:0]});
        xfer(1'b1, 32'(ADDR_CTRL), 32'h0);
        clkEn <= 1'b0;
        repeat (5) @(posedge clock);
        clkEn <= 1'b1;
        @(posedge clock);
        chk_applied(cur);
        $display("test lock and freeze done");
        end_sim;
    end
    // watchdog well beyond the expected couple hundred cycles
    initial
    begin
        #400000;
        fail_count++;
        end_sim;
    end
endmodule : boot_config_latches_test
`default_nettype wire
